// [src/isc_ctrl.v]
// Added by the designer: the Avalon-MM slave port and the register addresses.
`include "isc_regs.vh"

module isc_ctrl #(
	parameter NSRC = 32,
	parameter AW = 9
) (
	input wire clk_sys,
	input wire nrst,
	input wire [AW-1:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	output reg [31:0] avs_readdata,
	output reg avs_waitrequest,
	input wire [NSRC-1:0] src_req,
	input wire [31:0] normal_vector_in,
	input wire [31:0] fast_vector_in,
	output reg fast_irq_line_n,
	output reg normal_irq_line_n,
	output reg in_service,
	output reg irq
);

// ------------------------------------------------------------
// state
// ------------------------------------------------------------
reg [NSRC-1:0] pend_r;
reg [NSRC-1:0] pend_nxt;
reg [NSRC-1:0] mask_r;
reg [NSRC-1:0] mask_nxt;
reg [NSRC-1:0] ff_r;
reg [NSRC-1:0] ff_nxt;
reg [31:0] spu_r;
reg [1:0] dbg_r;
reg [`ISC_NUM_EV-1:0] evst_r;
reg [`ISC_NUM_EV-1:0] evst_nxt;
reg [`ISC_NUM_EV-1:0] evmsk_r;
reg svc_nxt;
reg [31:0] rd_nxt;
reg fast_act_r;
reg norm_act_r;

wire wr_go;
wire rd_go;
wire [NSRC-1:0] live;
wire fast_c;
wire norm_c;
wire [NSRC-1:0] wd;
wire [`ISC_NUM_EV-1:0] ev;
wire nvec_rd;
wire fvec_rd;
wire protection_mode_bit_start;
wire fast_q;
wire norm_q;
wire wr_spu;
wire wr_dbg;
wire wr_evmsk;
wire wr_evst;
wire wr_eos;

function hit;
	input [AW-1:0] a;
	input [AW-1:0] ofs;
	begin
		hit = (a == ofs);
	end
endfunction

// line request qualified by the general mask
function gate;
	input cond;
	input global_line_mask;
	begin
		gate = cond & ~global_line_mask;
	end
endfunction

// ------------------------------------------------------------
// bus handshake: one wait state, effect at waitrequest low
// ------------------------------------------------------------
assign wr_go = avs_write & ~avs_waitrequest;
assign rd_go = avs_read & ~avs_waitrequest;
assign wd = avs_writedata[NSRC-1:0];

always @(posedge clk_sys or negedge nrst) begin
	if (!nrst) begin
		avs_waitrequest <= 1'b1;
	end else if ((avs_read | avs_write) & avs_waitrequest) begin
		avs_waitrequest <= 1'b0;
	end else begin
		avs_waitrequest <= 1'b1;
	end
end

// ------------------------------------------------------------
// line evaluation
// ------------------------------------------------------------
assign live = pend_r & mask_r;
// fast source plus fast-forced sources drive the fast line
assign fast_c = live[`ISC_FAST_BIT] | (|(live & ff_r));
// normal line held off while a treatment is current
assign norm_c = (|(live & ~ff_r & ~{{(NSRC-1){1'b0}}, 1'b1})) & ~in_service;
assign nvec_rd = rd_go & hit(avs_address, `ISC_OFS_NVEC);
assign fvec_rd = rd_go & hit(avs_address, `ISC_OFS_FVEC);
// in protection mode a vector read does not start service but can still log the spurious event; a write starts service
assign protection_mode_bit_start = wr_go & hit(avs_address, `ISC_OFS_NVEC) & dbg_r[`ISC_DBG_PROTECTION_MODE_BIT];
assign fast_q = gate(fast_c, dbg_r[`ISC_DBG_GLOBAL_LINE_MASK]);
assign norm_q = gate(norm_c, dbg_r[`ISC_DBG_GLOBAL_LINE_MASK]);

// ------------------------------------------------------------
// register write strobes
// ------------------------------------------------------------
assign wr_spu = wr_go & hit(avs_address, `ISC_OFS_SPU);
assign wr_dbg = wr_go & hit(avs_address, `ISC_OFS_DBG);
assign wr_evmsk = wr_go & hit(avs_address, `ISC_OFS_EVMSK);
assign wr_evst = wr_go & hit(avs_address, `ISC_OFS_EVST);
assign wr_eos = wr_go & hit(avs_address, `ISC_OFS_EOS);

// ------------------------------------------------------------
// pending, mask and fast-force next state
// ------------------------------------------------------------
always @* begin
	pend_nxt = pend_r;
	mask_nxt = mask_r;
	ff_nxt = ff_r;
	if (wr_go & hit(avs_address, `ISC_OFS_ICLR)) begin
		pend_nxt = pend_nxt & ~wd;
	end
	// a source request in the clear cycle still wins
	pend_nxt = pend_nxt | src_req;
	if (wr_go & hit(avs_address, `ISC_OFS_ISET)) begin
		pend_nxt = pend_nxt | wd;
	end
	if (wr_go & hit(avs_address, `ISC_OFS_IEN)) begin
		mask_nxt = mask_r | wd;
	end
	if (wr_go & hit(avs_address, `ISC_OFS_IDIS)) begin
		mask_nxt = mask_r & ~wd;
	end
	if (wr_go & hit(avs_address, `ISC_OFS_FFEN)) begin
		ff_nxt = ff_r | (wd & `ISC_FF_MASK);
	end
	if (wr_go & hit(avs_address, `ISC_OFS_FFDIS)) begin
		ff_nxt = ff_r & ~(wd & `ISC_FF_MASK);
	end
end

// ------------------------------------------------------------
// service tracking
// ------------------------------------------------------------
always @* begin
	svc_nxt = in_service;
	if (wr_eos) begin
		svc_nxt = 1'b0;
	end else if (nvec_rd & norm_c & ~dbg_r[`ISC_DBG_PROTECTION_MODE_BIT]) begin
		svc_nxt = 1'b1;
	end else if (protection_mode_bit_start & norm_c) begin
		svc_nxt = 1'b1;
	end
end

// ------------------------------------------------------------
// read data
// ------------------------------------------------------------
always @* begin
	rd_nxt = `ISC_RST_WORD;
	case (avs_address)
	`ISC_OFS_NVEC: rd_nxt = norm_c ? normal_vector_in : spu_r;
	`ISC_OFS_FVEC: rd_nxt = fast_c ? fast_vector_in : spu_r;
	`ISC_OFS_PEND: rd_nxt = pend_r;
	`ISC_OFS_MASK: rd_nxt = mask_r;
	`ISC_OFS_CORE: rd_nxt = {30'h0, norm_act_r, fast_act_r};
	`ISC_OFS_SPU: rd_nxt = spu_r;
	`ISC_OFS_DBG: rd_nxt = {30'h0, dbg_r};
	`ISC_OFS_EVST: rd_nxt = {28'h0, evst_r};
	`ISC_OFS_EVMSK: rd_nxt = {28'h0, evmsk_r};
	default: rd_nxt = `ISC_RST_WORD;
	endcase
end

// ------------------------------------------------------------
// event status, write one to clear, set wins
// ------------------------------------------------------------
// a line event is the cycle in which that line goes active
assign ev[`ISC_EV_FAST] = fast_q & ~fast_act_r;
assign ev[`ISC_EV_NORM] = norm_q & ~norm_act_r;
assign ev[`ISC_EV_SPUR] = (nvec_rd & ~norm_c) | (fvec_rd & ~fast_c);
assign ev[`ISC_EV_EOS] = wr_eos;

always @* begin
	evst_nxt = evst_r;
	if (wr_evst) begin
		evst_nxt = evst_r & ~avs_writedata[`ISC_NUM_EV-1:0];
	end
	evst_nxt = evst_nxt | ev;
end

// ------------------------------------------------------------
// pending flags
// ------------------------------------------------------------
always @(posedge clk_sys or negedge nrst) begin
	if (!nrst) begin
		pend_r <= {NSRC{1'b0}};
	end else begin
		pend_r <= pend_nxt;
	end
end

// ------------------------------------------------------------
// source mask
// ------------------------------------------------------------
always @(posedge clk_sys or negedge nrst) begin
	if (!nrst) begin
		mask_r <= {NSRC{1'b0}};
	end else begin
		mask_r <= mask_nxt;
	end
end

// ------------------------------------------------------------
// fast-force selection
// ------------------------------------------------------------
always @(posedge clk_sys or negedge nrst) begin
	if (!nrst) begin
		ff_r <= {NSRC{1'b0}};
	end else begin
		ff_r <= ff_nxt;
	end
end

// ------------------------------------------------------------
// event status
// ------------------------------------------------------------
always @(posedge clk_sys or negedge nrst) begin
	if (!nrst) begin
		evst_r <= {`ISC_NUM_EV{1'b0}};
	end else begin
		evst_r <= evst_nxt;
	end
end

// ------------------------------------------------------------
// current treatment flag
// ------------------------------------------------------------
// held until the end-of-service write
always @(posedge clk_sys or negedge nrst) begin
	if (!nrst) begin
		in_service <= 1'b0;
	end else begin
		in_service <= svc_nxt;
	end
end

// ------------------------------------------------------------
// spurious vector
// ------------------------------------------------------------
always @(posedge clk_sys or negedge nrst) begin
	if (!nrst) begin
		spu_r <= `ISC_RST_WORD;
	end else if (wr_spu) begin
		spu_r <= avs_writedata;
	end
end

// ------------------------------------------------------------
// debug control
// ------------------------------------------------------------
always @(posedge clk_sys or negedge nrst) begin
	if (!nrst) begin
		dbg_r <= 2'h0;
	end else if (wr_dbg) begin
		dbg_r <= avs_writedata[1:0];
	end
end

// ------------------------------------------------------------
// event mask
// ------------------------------------------------------------
always @(posedge clk_sys or negedge nrst) begin
	if (!nrst) begin
		evmsk_r <= {`ISC_NUM_EV{1'b0}};
	end else if (wr_evmsk) begin
		evmsk_r <= avs_writedata[`ISC_NUM_EV-1:0];
	end
end

// ------------------------------------------------------------
// read data
// ------------------------------------------------------------
// loaded in the wait cycle, stands at the answer edge
always @(posedge clk_sys or negedge nrst) begin
	if (!nrst) begin
		avs_readdata <= `ISC_RST_WORD;
	end else if (avs_read & avs_waitrequest) begin
		avs_readdata <= rd_nxt;
	end
end

// ------------------------------------------------------------
// fast line state
// ------------------------------------------------------------
always @(posedge clk_sys or negedge nrst) begin
	if (!nrst) begin
		fast_act_r <= 1'b0;
	end else begin
		fast_act_r <= fast_q;
	end
end

// ------------------------------------------------------------
// normal line state
// ------------------------------------------------------------
always @(posedge clk_sys or negedge nrst) begin
	if (!nrst) begin
		norm_act_r <= 1'b0;
	end else begin
		norm_act_r <= norm_q;
	end
end

// ------------------------------------------------------------
// fast line output
// ------------------------------------------------------------
// general mask ties both lines inactive
always @(posedge clk_sys or negedge nrst) begin
	if (!nrst) begin
		fast_irq_line_n <= 1'b1;
	end else begin
		fast_irq_line_n <= ~fast_q;
	end
end

// ------------------------------------------------------------
// normal line output
// ------------------------------------------------------------
always @(posedge clk_sys or negedge nrst) begin
	if (!nrst) begin
		normal_irq_line_n <= 1'b1;
	end else begin
		normal_irq_line_n <= ~norm_q;
	end
end

// ------------------------------------------------------------
// event interrupt
// ------------------------------------------------------------
always @(posedge clk_sys or negedge nrst) begin
	if (!nrst) begin
		irq <= 1'b0;
	end else begin
		irq <= |(evst_nxt & evmsk_r);
	end
end

endmodule

// [src/isc_regs.vh]
`ifndef ISC_REGS_VH
`define ISC_REGS_VH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define ISC_OFS_NVEC 9'h100
`define ISC_OFS_FVEC 9'h104
`define ISC_OFS_PEND 9'h10C
`define ISC_OFS_MASK 9'h110
`define ISC_OFS_CORE 9'h114
`define ISC_OFS_IEN 9'h120
`define ISC_OFS_IDIS 9'h124
`define ISC_OFS_ICLR 9'h128
`define ISC_OFS_ISET 9'h12C
`define ISC_OFS_EOS 9'h130
`define ISC_OFS_SPU 9'h134
`define ISC_OFS_DBG 9'h138
`define ISC_OFS_FFEN 9'h140
`define ISC_OFS_FFDIS 9'h144
`define ISC_OFS_EVST 9'h150
`define ISC_OFS_EVMSK 9'h154

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define ISC_FAST_BIT 0
`define ISC_SYS_BIT 1
`define ISC_LINE_FAST 0
`define ISC_LINE_NORM 1
`define ISC_DBG_PROTECTION_MODE_BIT 0
`define ISC_DBG_GLOBAL_LINE_MASK 1
`define ISC_EV_FAST 0
`define ISC_EV_NORM 1
`define ISC_EV_SPUR 2
`define ISC_EV_EOS 3

// ------------------------------------------------------------
// reset values and widths
// ------------------------------------------------------------
`define ISC_RST_WORD 32'h0000_0000
`define ISC_DBG_MASK 32'h0000_0003
`define ISC_FF_MASK 32'hFFFF_FFFE
`define ISC_EV_MASK 32'h0000_000F
`define ISC_NUM_EV 4

`endif

// [verification/isc_ctrl_checker.sv]
module isc_ctrl_checker (
	input logic clk_sys,
	input logic nrst,
	input logic [8:0] avs_address,
	input logic avs_read,
	input logic avs_write,
	input logic [31:0] avs_writedata,
	input logic [31:0] avs_readdata,
	input logic avs_waitrequest,
	input logic fast_irq_line_n,
	input logic normal_irq_line_n,
	input logic in_service
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	logic global_line_mask_r;
	logic [31:0] spu_r;
	wire wdone = avs_write && !avs_waitrequest;
	// shadow of the mask bit and vector as software wrote them
	always @(posedge clk_sys or negedge nrst)
		if (!nrst) begin
			global_line_mask_r <= 1'h0;
			spu_r <= 32'h0;
		end else if (wdone && avs_address == 9'h138)
			global_line_mask_r <= avs_writedata[1];
		else if (wdone && avs_address == 9'h134)
			spu_r <= avs_writedata;
	wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("wait low");
	wait_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("no answer");
	wait_idle_a: assert property (!(avs_read || avs_write) |=> avs_waitrequest) else $error("idle");
	rdata_hold_a: assert property (!avs_read |=> $stable(avs_readdata)) else $error("rdata");
	hole_zero_a: assert property (avs_read && !avs_waitrequest && avs_address == 9'h1FC
		|-> avs_readdata == 32'h0) else $error("hole");
	global_line_mask_quiet_a: assert property (global_line_mask_r |=> fast_irq_line_n && normal_irq_line_n)
		else $error("lines");
	eos_end_a: assert property (wdone && avs_address == 9'h130 |-> ##2 !in_service)
		else $error("service");
	spu_back_a: assert property (avs_read && !avs_waitrequest && avs_address == 9'h134
		|-> avs_readdata == spu_r) else $error("spu");
endmodule
bind isc_ctrl isc_ctrl_checker u_isc_ctrl_checker (.clk_sys, .nrst, .avs_address, .avs_read,
	.avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .fast_irq_line_n,
	.normal_irq_line_n, .in_service);

// [verification/isc_far_model.sv]
module isc_far_model #(
	parameter logic [31:0] NVEC = 32'h0000_1000,
	parameter logic [31:0] FVEC = 32'h0000_2000
) (
	input logic clk_sys,
	input logic [31:0] raise,
	input logic fast_irq_line_n,
	input logic normal_irq_line_n,
	output logic [31:0] src_req,
	output logic [31:0] normal_vector_in,
	output logic [31:0] fast_vector_in,
	output logic [1:0] core_seen
);
	timeunit 1ns;
	timeprecision 1ns;
	assign normal_vector_in = NVEC;
	assign fast_vector_in = FVEC;
	initial src_req = '0;
	always @(posedge clk_sys) begin
		src_req <= raise;
		core_seen <= {!normal_irq_line_n, !fast_irq_line_n};
	end
endmodule

// [verification/test_interrupt_status_command_regs.sv]
module test_interrupt_status_command_regs;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] NV = 32'h0000_1230;
	localparam logic [31:0] FV = 32'h0000_4560;
	localparam logic [31:0] SV = 32'hA5A5_0F0F;
	logic clk_sys = 0, nrst = 0, avs_read = 0, avs_write = 0;
	logic [8:0] avs_address = '0;
	logic [31:0] avs_writedata = '0, raise = '0, rd;
	wire [31:0] avs_readdata, src_req, nvec, fvec;
	wire avs_waitrequest, fln, nln, in_service, irq;
	wire [1:0] core_seen;
	int num_errors = 0, cmp_count = 0;
	isc_ctrl u_isc_ctrl (.clk_sys, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_readdata, .avs_waitrequest, .src_req, .normal_vector_in(nvec),
		.fast_vector_in(fvec), .fast_irq_line_n(fln), .normal_irq_line_n(nln), .in_service, .irq);
	isc_far_model #(.NVEC(NV), .FVEC(FV)) u_isc_far_model (.clk_sys, .raise,
		.fast_irq_line_n(fln), .normal_irq_line_n(nln), .src_req, .normal_vector_in(nvec),
		.fast_vector_in(fvec), .core_seen);
	initial forever #5 clk_sys = ~clk_sys;
	task automatic final_report();
		$display("compares %0d errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic bus(input logic [8:0] a, input logic w, input logic [31:0] d);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		@(posedge clk_sys);
		while (avs_waitrequest !== 1'h0) @(posedge clk_sys);
		rd = avs_readdata;
		avs_write <= 1'h0;
		avs_read <= 1'h0;
		@(posedge clk_sys);
	endtask
	task automatic rc(input logic [8:0] a, input logic [31:0] e);
		bus(a, 1'h0, 32'h0);
		chk($sformatf("reg %h", a), e, rd);
	endtask
	initial begin
		repeat (5) @(posedge clk_sys);
		nrst <= 1'h1;
		@(posedge clk_sys);
		rc(9'h110, 32'h0);
		rc(9'h134, 32'h0);
		rc(9'h138, 32'h0);
		raise <= 32'h8;
		bus(9'h120, 1'h1, 32'h8000_0006);
		bus(9'h124, 1'h1, 32'h2);
		rc(9'h110, 32'h8000_0004);
		bus(9'h120, 1'h1, 32'h2);
		rc(9'h110, 32'h8000_0006);
		bus(9'h12C, 1'h1, 32'h8000_0004);
		rc(9'h10C, 32'h8000_000C);
		raise <= '0;
		bus(9'h128, 1'h1, 32'h8000_0008);
		rc(9'h10C, 32'h4);
		rc(9'h114, 32'h2);
		chk("core", 32'h2, {30'h0, core_seen});
		bus(9'h138, 1'h1, 32'h2);
		rc(9'h114, 32'h0);
		bus(9'h138, 1'h1, 32'h1);
		rc(9'h138, 32'h1);
		rc(9'h100, NV);
		chk("in_service", 32'h0, {31'h0, in_service});
		bus(9'h138, 1'h1, 32'h0);
		bus(9'h134, 1'h1, SV);
		rc(9'h104, SV);
		rc(9'h100, NV);
		@(posedge clk_sys);
		chk("in_service", 32'h1, {31'h0, in_service});
		bus(9'h130, 1'h1, 32'hDEAD_BEEF);
		@(posedge clk_sys);
		chk("in_service", 32'h0, {31'h0, in_service});
		bus(9'h140, 1'h1, 32'h5);
		rc(9'h114, 32'h1);
		chk("core", 32'h1, {30'h0, core_seen});
		rc(9'h104, FV);
		bus(9'h144, 1'h1, 32'h5);
		rc(9'h114, 32'h2);
		bus(9'h154, 1'h1, 32'h0);
		@(posedge clk_sys);
		chk("irq", 32'h0, {31'h0, irq});
		bus(9'h154, 1'h1, 32'hF);
		@(posedge clk_sys);
		chk("irq", 32'h1, {31'h0, irq});
		rc(9'h150, 32'hF);
		bus(9'h128, 1'h1, 32'hFFFF_FFFF);
		rc(9'h100, SV);
		bus(9'h150, 1'h1, 32'hF);
		rc(9'h150, 32'h0);
		chk("irq", 32'h0, {31'h0, irq});
		rc(9'h1FC, 32'h0);
		final_report();
	end
	initial begin
		repeat (3000) @(posedge clk_sys);
		num_errors++;
		final_report();
	end
endmodule
